// ===== mmad_defines.vh
`ifndef MMAD_DEFINES_VH
`define MMAD_DEFINES_VH

// bus widths
`define MMAD_AD_W        8
`define MMAD_HI_W        5
`define MMAD_ADDR_W      13
`define MMAD_NV_OFS_W    10

// peripheral windows, inclusive bounds on the full address
`define MMAD_RTC_LO      13'h0080
`define MMAD_RTC_HI      13'h008f
`define MMAD_SER_LO      13'h0090
`define MMAD_SER_HI      13'h0093
`define MMAD_DISP_ADDR   13'h00a0
`define MMAD_VOICE_ADDR  13'h00b0
`define MMAD_EXP_LO      13'h00c2
`define MMAD_EXP_HI      13'h00c8

// memory windows, inclusive bounds on the full address
`define MMAD_NV_LO       13'h0100
`define MMAD_NV_HI       13'h04ff
`define MMAD_ROM_LO      13'h0500
`define MMAD_ROM_HI      13'h1fff

// reset value of the holding latch (an unmapped address)
`define MMAD_ADDR_RST    13'h0000

// clock rate and time-of-day constants
`define MMAD_CLK_HZ      40000000
`define MMAD_SEC_PERIOD_S 1
`define MMAD_TONE_HZ     1024
`define MMAD_HOURS_MAX   5'h17
`define MMAD_MINSEC_MAX  6'h3b

`endif

// ===== mmad_sync.v
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for a bundle of asynchronous pin levels
module mmad_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_q;    // first stage, read only by the second stage

    // both stages clear on reset, then follow the pins
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // mmad_sync

`default_nettype wire

// ===== mmad_rtc.v
`timescale 1ns/1ps
`default_nettype none
`include "mmad_defines.vh"

// time-of-day counter in 24-hour form with a square-wave tone output
module mmad_rtc #(
    parameter SEC_CYCLES  = `MMAD_CLK_HZ * `MMAD_SEC_PERIOD_S,
    parameter HALF_CYCLES = `MMAD_CLK_HZ / (2 * `MMAD_TONE_HZ)
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       tone_enable,
    output reg  [4:0] hours_q,
    output reg  [5:0] minutes_q,
    output reg  [5:0] seconds_q,
    output reg        tone_square_wave_out
);

    reg  [31:0] sec_cnt_q;   // cycles within the current second
    reg  [31:0] tone_cnt_q;  // cycles within the current half period
    wire        sec_tick;    // last cycle of a second

    assign sec_tick = (sec_cnt_q == SEC_CYCLES - 1);

    // seconds, minutes and hours roll over at 59, 59 and 23
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sec_cnt_q <= 32'h0000_0000;
            seconds_q <= 6'h00;
            minutes_q <= 6'h00;
            hours_q   <= 5'h00;
        end
        else if (sec_tick)
        begin
            sec_cnt_q <= 32'h0000_0000;
            if (seconds_q == `MMAD_MINSEC_MAX)
            begin
                seconds_q <= 6'h00;
                if (minutes_q == `MMAD_MINSEC_MAX)
                begin
                    minutes_q <= 6'h00;
                    // wrap after hour 23, never shows 24
                    if (hours_q == `MMAD_HOURS_MAX)
                        hours_q <= 5'h00;
                    else
                        hours_q <= hours_q + 5'h01;
                end
                else
                    minutes_q <= minutes_q + 6'h01;
            end
            else
                seconds_q <= seconds_q + 6'h01;
        end
        else
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end

    // keypad beep tone, held low while the tone is off
    always @(posedge clk)
    begin
        if (!rst_n || !tone_enable)
        begin
            tone_cnt_q           <= 32'h0000_0000;
            tone_square_wave_out <= 1'b0;
        end
        else if (tone_cnt_q == HALF_CYCLES - 1)
        begin
            tone_cnt_q           <= 32'h0000_0000;
            tone_square_wave_out <= ~tone_square_wave_out;
        end
        else
            tone_cnt_q <= tone_cnt_q + 32'h0000_0001;
    end

endmodule // mmad_rtc

`default_nettype wire

// ===== mmad_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mmad_defines.vh"

// address latch and memory map decoder for a multiplexed bus
//
// timing, counted from the clock edge that launches the strobe pin:
//   edge 1  first flop takes strobe and address pins together
//   edge 2  second flop; the strobe rise is seen here
//   edge 3  holding latch loads the address
//   edge 4  selects, enables and address lines update
// the outputs then stand until the next strobe rise moves them
module mmad_top #(
    parameter SEC_CYCLES  = `MMAD_CLK_HZ * `MMAD_SEC_PERIOD_S,
    parameter HALF_CYCLES = `MMAD_CLK_HZ / (2 * `MMAD_TONE_HZ)
) (
    // clock and synchronous active-low reset
    input  wire                       clk,
    input  wire                       rst_n,
    // processor side pins, all outside the clock domain
    input  wire [`MMAD_AD_W-1:0]      ad_bus,
    input  wire [`MMAD_HI_W-1:0]      addr_hi,
    input  wire                       address_latch_strobe,
    input  wire                       tone_enable,
    // peripheral selects, active low
    output reg                        clock_select_n,
    output reg                        serial_select_n,
    output reg                        display_select_n,
    output reg                        voice_select_n,
    output reg                        expander_select_n,
    output reg                        nvram_enable_n,
    output reg                        eprom_enable_n,
    // memory-side address lines and map status
    output reg  [`MMAD_NV_OFS_W-1:0]  nvram_addr_q,
    output reg  [`MMAD_ADDR_W-1:0]    eprom_addr_q,
    output reg                        unmapped_q,
    // time of day and keypad beep tone
    output wire [4:0]                 rtc_hours,
    output wire [5:0]                 rtc_minutes,
    output wire [5:0]                 rtc_seconds,
    output wire                       tone_square_wave_out
);

    // width of the bundle of pins that pass the synchroniser
    localparam SYNC_W = `MMAD_AD_W + `MMAD_HI_W + 2;

    // reset address, split into the halves of the holding latch
    localparam [`MMAD_ADDR_W-1:0] ADDR_RST    = `MMAD_ADDR_RST;
    localparam [`MMAD_AD_W-1:0]   ADDR_LO_RST = ADDR_RST[`MMAD_AD_W-1:0];
    localparam [`MMAD_HI_W-1:0]   ADDR_HI_RST =
        ADDR_RST[`MMAD_ADDR_W-1:`MMAD_AD_W];

    // idle values of the memory-side address lines
    localparam [`MMAD_NV_OFS_W-1:0] NV_ADDR_IDLE  = {`MMAD_NV_OFS_W{1'b0}};
    localparam [`MMAD_ADDR_W-1:0]   ROM_ADDR_IDLE = {`MMAD_ADDR_W{1'b0}};

    // true when an address lies in an inclusive window
    // (both bounds belong to the window)
    function in_window;
        input [`MMAD_ADDR_W-1:0] addr;
        input [`MMAD_ADDR_W-1:0] lo;
        input [`MMAD_ADDR_W-1:0] hi;
        begin
            in_window = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // synchronised pin bundle and its unpacked fields
    wire [SYNC_W-1:0]         pins_async;   // raw pins, outside the clock
    wire [SYNC_W-1:0]         pins_sync;    // after two flip-flops
    wire [`MMAD_AD_W-1:0]     ad_s;         // multiplexed address/data
    wire [`MMAD_HI_W-1:0]     hi_s;         // upper address lines
    wire                      strobe_s;     // address strobe level
    wire                      tone_en_s;    // tone request level

    // latch state and strobe edge detection
    reg                       strobe_prev_q;  // strobe level last cycle
    wire                      strobe_rise;    // strobe went high
    reg  [`MMAD_AD_W-1:0]     addr_lo_q;      // holding latch, low byte
    reg  [`MMAD_HI_W-1:0]     addr_hi_q;      // upper lines at the strobe
    wire [`MMAD_ADDR_W-1:0]   addr_full;      // decoded address

    // next values of the decoder outputs
    reg                       clk_sel_d;     // clock window hit
    reg                       ser_sel_d;     // serial window hit
    reg                       disp_sel_d;    // display address hit
    reg                       voice_sel_d;   // voice address hit
    reg                       exp_sel_d;     // expander window hit
    reg                       nv_sel_d;      // RAM window hit
    reg                       rom_sel_d;     // EPROM window hit
    wire                      any_hit_d;     // some window matched
    reg  [`MMAD_ADDR_W-1:0]   nv_ofs_full;   // RAM offset before trim

    // gather every asynchronous pin into one bundle
    // so a single synchroniser instance serves them all
    assign pins_async = {tone_enable, address_latch_strobe, addr_hi,
                         ad_bus};

    // two flip-flops ahead of any logic that reads a pin; address and
    // strobe travel through the same stages, so they stay aligned and
    // the address must stand at the pins from one clock before the
    // strobe rises until one clock after it
    mmad_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // split the synchronised bundle back into its fields
    // (the order matches the concatenation that built the bundle)
    assign ad_s      = pins_sync[`MMAD_AD_W-1:0];
    assign hi_s      = pins_sync[`MMAD_AD_W+`MMAD_HI_W-1:`MMAD_AD_W];
    assign strobe_s  = pins_sync[`MMAD_AD_W+`MMAD_HI_W];
    assign tone_en_s = pins_sync[`MMAD_AD_W+`MMAD_HI_W+1];

    // a rising strobe is seen on the synchronised level only; a pulse
    // shorter than one clock may slip between the samples
    assign strobe_rise = strobe_s & ~strobe_prev_q;

    // remember the strobe level for edge detection
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // idle level of the pin, so no false edge after reset
            strobe_prev_q <= 1'b0;
        end
        else
        begin
            // one cycle behind the synchronised strobe
            strobe_prev_q <= strobe_s;
        end
    end

    // holding latch: the bus carries the address only near the strobe,
    // so the low byte is caught there and held until the next strobe
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // reset points at an unmapped address so nothing is selected
            addr_lo_q <= ADDR_LO_RST;
            addr_hi_q <= ADDR_HI_RST;
        end
        else if (strobe_rise)
        begin
            // catch both halves of the address at the strobe
            addr_lo_q <= ad_s;
            addr_hi_q <= hi_s;
        end
        else
        begin
            // between strobes the bus carries data; keep the address
            addr_lo_q <= addr_lo_q;
            addr_hi_q <= addr_hi_q;
        end
    end

    // the decoded address joins the held upper lines to the latch
    assign addr_full = {addr_hi_q, addr_lo_q};

    // window decode; the chain makes the hits mutually exclusive even
    // if a window constant is ever edited to overlap another;
    // the peripheral windows need the upper lines at zero, since they
    // are compared against the full thirteen-bit address
    always @*
    begin
        clk_sel_d   = 1'b0;
        ser_sel_d   = 1'b0;
        disp_sel_d  = 1'b0;
        voice_sel_d = 1'b0;
        exp_sel_d   = 1'b0;
        nv_sel_d    = 1'b0;
        rom_sel_d   = 1'b0;
        // peripheral windows first, all in the low page
        if (in_window(addr_full, `MMAD_RTC_LO, `MMAD_RTC_HI))
            clk_sel_d = 1'b1;
        else if (in_window(addr_full, `MMAD_SER_LO, `MMAD_SER_HI))
            ser_sel_d = 1'b1;
        else if (addr_full == `MMAD_DISP_ADDR)
            disp_sel_d = 1'b1;
        else if (addr_full == `MMAD_VOICE_ADDR)
            voice_sel_d = 1'b1;
        else if (in_window(addr_full, `MMAD_EXP_LO, `MMAD_EXP_HI))
            exp_sel_d = 1'b1;
        // then the two memory windows
        else if (in_window(addr_full, `MMAD_NV_LO, `MMAD_NV_HI))
            nv_sel_d = 1'b1;
        else if (in_window(addr_full, `MMAD_ROM_LO, `MMAD_ROM_HI))
            rom_sel_d = 1'b1;
        else
        begin
            // gaps in the map select nothing
            clk_sel_d = 1'b0;
        end
    end

    // RAM offset: only 1024 bytes of the part lie in the window;
    // the difference is thirteen bits, only its low ten reach the pins
    always @*
    begin
        nv_ofs_full = addr_full - `MMAD_NV_LO;
    end

    // one "some window matched" term keeps the unmapped flag in step
    // with the selects, since it is built from the very same hits
    assign any_hit_d = clk_sel_d | ser_sel_d | disp_sel_d | voice_sel_d |
                       exp_sel_d | nv_sel_d  | rom_sel_d;

    // registered, active-low selects; all high during reset
    // registering them keeps decode glitches off the select pins while
    // the latch and the comparators settle
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // nothing is selected while in reset
            clock_select_n    <= 1'b1;
            serial_select_n   <= 1'b1;
            display_select_n  <= 1'b1;
            voice_select_n    <= 1'b1;
            expander_select_n <= 1'b1;
            nvram_enable_n    <= 1'b1;
            eprom_enable_n    <= 1'b1;
        end
        else
        begin
            // low while the window is decoded, high otherwise
            clock_select_n    <= ~clk_sel_d;
            serial_select_n   <= ~ser_sel_d;
            display_select_n  <= ~disp_sel_d;
            voice_select_n    <= ~voice_sel_d;
            expander_select_n <= ~exp_sel_d;
            // the memory enables follow the same rule as the selects
            nvram_enable_n    <= ~nv_sel_d;
            eprom_enable_n    <= ~rom_sel_d;
        end
    end

    // memory-side address lines and the unmapped flag
    // the lines idle at zero whenever their part is not enabled
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // idle address lines; the held address is unmapped
            nvram_addr_q <= NV_ADDR_IDLE;
            eprom_addr_q <= ROM_ADDR_IDLE;
            unmapped_q   <= 1'b1;
        end
        else
        begin
            // upper RAM bytes are never addressed
            if (nv_sel_d)
                nvram_addr_q <= nv_ofs_full[`MMAD_NV_OFS_W-1:0];
            else
                nvram_addr_q <= NV_ADDR_IDLE;  // RAM not selected
            // the EPROM sees the address as is, so only its top
            // bytes from 500H upward are ever reached
            if (rom_sel_d)
                eprom_addr_q <= addr_full;
            else
                eprom_addr_q <= ROM_ADDR_IDLE; // EPROM not selected
            // no window at all matched the held address
            unmapped_q <= ~any_hit_d;
        end
    end

    // time-of-day clock with its beep tone generator; the second and
    // half-period counts are parameters so a simulation can shorten
    // them, and the tone rate is a choice of ours, not of the clock
    mmad_rtc #(
        .SEC_CYCLES           (SEC_CYCLES),
        .HALF_CYCLES          (HALF_CYCLES)
    ) u_rtc (
        .clk                  (clk),
        .rst_n                (rst_n),
        .tone_enable          (tone_en_s),
        .hours_q              (rtc_hours),
        .minutes_q            (rtc_minutes),
        .seconds_q            (rtc_seconds),
        .tone_square_wave_out (tone_square_wave_out)
    );

endmodule // mmad_top

`default_nettype wire

// ===== mmad_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
// decode, hold and timekeeping properties on the top-level pins
module mmad_chk #(
    parameter SEC_CYCLES  = 40000000,
    parameter HALF_CYCLES = 19531
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  ad_bus,
    input wire logic [4:0]  addr_hi,
    input wire logic        address_latch_strobe,
    input wire logic        tone_enable,
    input wire logic        clock_select_n,
    input wire logic        serial_select_n,
    input wire logic        display_select_n,
    input wire logic        voice_select_n,
    input wire logic        expander_select_n,
    input wire logic        nvram_enable_n,
    input wire logic        eprom_enable_n,
    input wire logic [9:0]  nvram_addr_q,
    input wire logic [12:0] eprom_addr_q,
    input wire logic        unmapped_q,
    input wire logic [4:0]  rtc_hours,
    input wire logic [5:0]  rtc_minutes,
    input wire logic [5:0]  rtc_seconds,
    input wire logic        tone_square_wave_out
);
    logic        stb_q; // strobe pin one clock ago
    logic [12:0] a;     // full address on the pins
    logic        rise;  // strobe pin seen rising
    logic [6:0]  sel;   // every enable, active low
    logic h_rtc, h_ser, h_disp, h_voice, h_exp, h_nv, h_rom; // window hits
    assign a = {addr_hi, ad_bus};
    assign rise = address_latch_strobe & ~stb_q;
    assign sel = {eprom_enable_n, nvram_enable_n, expander_select_n,
                  voice_select_n, display_select_n, serial_select_n,
                  clock_select_n};
    assign h_rtc = a >= 13'h0080 && a <= 13'h008f;
    assign h_ser = a >= 13'h0090 && a <= 13'h0093;
    assign h_disp = a == 13'h00a0;
    assign h_voice = a == 13'h00b0;
    assign h_exp = a >= 13'h00c2 && a <= 13'h00c8;
    assign h_nv = a >= 13'h0100 && a <= 13'h04ff;
    assign h_rom = a >= 13'h0500;
    // previous strobe level, for edge detection
    always @(posedge clk)
        stb_q <= address_latch_strobe;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rtc_window_a: assert property (rise |-> ##4
        clock_select_n == !$past(h_rtc, 4)) else $error("clock select");
    serial_window_a: assert property (rise |-> ##4
        serial_select_n == !$past(h_ser, 4)) else $error("serial select");
    display_addr_a: assert property (rise |-> ##4
        display_select_n == !$past(h_disp, 4)) else $error("display");
    voice_addr_a: assert property (rise |-> ##4
        voice_select_n == !$past(h_voice, 4)) else $error("voice select");
    expander_window_a: assert property (rise |-> ##4
        expander_select_n == !$past(h_exp, 4)) else $error("expander");
    nvram_window_a: assert property (rise |-> ##4
        nvram_enable_n == !$past(h_nv, 4) && nvram_addr_q ==
        ($past(h_nv, 4) ? $past(a[9:0], 4) - 10'h100 : 10'h000))
        else $error("ram enable");
    eprom_window_a: assert property (rise |-> ##4
        eprom_enable_n == !$past(h_rom, 4) && eprom_addr_q ==
        ($past(h_rom, 4) ? $past(a, 4) : 13'h0000)) else $error("eprom");
    one_select_a: assert property ($onehot0(~sel))
        else $error("two selects low");
    select_hold_a: assert property (!$past(rise, 4) |-> $stable(sel))
        else $error("select moved without strobe");
    time_range_a: assert property (rtc_hours <= 5'h17 &&
        rtc_minutes <= 6'h3b && rtc_seconds <= 6'h3b) else $error("time");
    tone_off_a: assert property (!tone_enable [*4] |=>
        !tone_square_wave_out) else $error("tone while off");
endmodule // mmad_chk

bind mmad_top mmad_chk #(.SEC_CYCLES(SEC_CYCLES),
    .HALF_CYCLES(HALF_CYCLES)) u_mmad_chk (.clk(clk), .rst_n(rst_n),
    .ad_bus(ad_bus), .addr_hi(addr_hi), .tone_enable(tone_enable),
    .address_latch_strobe(address_latch_strobe),
    .clock_select_n(clock_select_n), .serial_select_n(serial_select_n),
    .display_select_n(display_select_n), .voice_select_n(voice_select_n),
    .expander_select_n(expander_select_n), .unmapped_q(unmapped_q),
    .nvram_enable_n(nvram_enable_n), .eprom_enable_n(eprom_enable_n),
    .nvram_addr_q(nvram_addr_q), .eprom_addr_q(eprom_addr_q),
    .rtc_hours(rtc_hours), .rtc_minutes(rtc_minutes),
    .rtc_seconds(rtc_seconds), .tone_square_wave_out(tone_square_wave_out));
`default_nettype wire

// ===== mmad_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// processor model: one address phase on the multiplexed bus per start
module mmad_cpu (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic [12:0] addr,
    output var  logic [7:0]  ad_bus,
    output var  logic [4:0]  addr_hi,
    output var  logic        strobe,
    output var  logic        done
);
    // idle bus before the first cycle
    initial
    begin
        ad_bus = 8'h00;
        addr_hi = 5'h00;
        strobe = 1'b0;
        done = 1'b0;
    end
    // address 3 clocks before the strobe rise and 2 after, then the
    // bus turns to inverted data so a late sample reads a wrong address
    always @(posedge clk)
    begin
        if (start)
        begin
            ad_bus <= addr[7:0];
            addr_hi <= addr[12:8];
            repeat (3) @(posedge clk);
            strobe <= 1'b1;
            repeat (2) @(posedge clk);
            ad_bus <= ~addr[7:0];
            addr_hi <= ~addr[12:8];
            @(posedge clk);
            strobe <= 1'b0;
            repeat (2) @(posedge clk);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
        end
    end
endmodule // mmad_cpu
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SEC = 20; // shortened second
    localparam int HALF = 4; // shortened tone half period
    logic clk, rst_n, cpu_start, tone_enable, strb, done;
    logic [12:0] cpu_addr; // address handed to the processor model
    logic [7:0] ad_bus;
    logic [4:0] addr_hi, rtc_hours;
    logic [5:0] rtc_minutes, rtc_seconds;
    logic [9:0] nvram_addr_q;
    logic [12:0] eprom_addr_q;
    logic c_n, s_n, d_n, v_n, x_n, r_n, e_n, unmapped_q, tone;
    logic [6:0] sel; // every enable, active low
    int num_errors = 0;
    int check_count = 0;
    logic [12:0] tbl [0:19] = '{13'h007f, 13'h0080, 13'h008f, 13'h0090,
        13'h0093, 13'h0094, 13'h00a0, 13'h00a1, 13'h00b0, 13'h00b1,
        13'h00c1, 13'h00c2, 13'h00c8, 13'h00c9, 13'h00ff, 13'h0100,
        13'h04ff, 13'h0500, 13'h1fff, 13'h1080};
    assign sel = {e_n, r_n, x_n, v_n, d_n, s_n, c_n};
    mmad_top #(.SEC_CYCLES(SEC), .HALF_CYCLES(HALF)) u_mmad_top (
        .clk(clk), .rst_n(rst_n), .ad_bus(ad_bus), .addr_hi(addr_hi),
        .address_latch_strobe(strb), .tone_enable(tone_enable),
        .clock_select_n(c_n), .serial_select_n(s_n),
        .display_select_n(d_n), .voice_select_n(v_n),
        .expander_select_n(x_n), .nvram_enable_n(r_n),
        .eprom_enable_n(e_n), .nvram_addr_q(nvram_addr_q),
        .eprom_addr_q(eprom_addr_q), .unmapped_q(unmapped_q),
        .rtc_hours(rtc_hours), .rtc_minutes(rtc_minutes),
        .rtc_seconds(rtc_seconds), .tone_square_wave_out(tone));
    mmad_cpu u_mmad_cpu (.clk(clk), .start(cpu_start), .addr(cpu_addr),
        .ad_bus(ad_bus), .addr_hi(addr_hi), .strobe(strb), .done(done));
    // 25 ns clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task automatic check(input logic [12:0] seen, input logic [12:0] expv);
        begin
            check_count++;
            if (seen !== expv)
            begin
                num_errors++;
                $display("wrong value at %0t: saw %h expected %h", $time,
                    seen, expv);
            end
        end
    endtask
    // expected enables of a full address, active low
    function automatic logic [6:0] exp_sel(input logic [12:0] a);
        exp_sel = 7'h7f;
        if (a >= 13'h0080 && a <= 13'h008f) exp_sel[0] = 1'b0;
        if (a >= 13'h0090 && a <= 13'h0093) exp_sel[1] = 1'b0;
        if (a == 13'h00a0) exp_sel[2] = 1'b0;
        if (a == 13'h00b0) exp_sel[3] = 1'b0;
        if (a >= 13'h00c2 && a <= 13'h00c8) exp_sel[4] = 1'b0;
        if (a >= 13'h0100 && a <= 13'h04ff) exp_sel[5] = 1'b0;
        if (a >= 13'h0500) exp_sel[6] = 1'b0;
    endfunction
    // bit watched by the bounded wait
    function automatic logic probe(input int which);
        case (which)
            0: probe = rtc_seconds[0];
            1: probe = rtc_minutes[0];
            2: probe = tone;
            default: probe = done;
        endcase
    endfunction
    // counts clocks until the watched bit flips; a hang ends the run
    task automatic wait_flip(input int which, input int lim, output int n);
        logic v;
        begin
            v = probe(which);
            n = 0;
            while (probe(which) === v && n < lim)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= lim)
            begin
                num_errors++;
                print_verdict();
            end
        end
    endtask
    // one address phase through the processor model
    task automatic bus_cycle(input logic [12:0] a);
        int n;
        begin
            cpu_addr <= a;
            cpu_start <= 1'b1;
            @(posedge clk);
            cpu_start <= 1'b0;
            wait_flip(3, 40, n);
        end
    endtask
    // state right after reset: nothing selected, clock at midnight
    task automatic t_reset_state;
        begin
            check({6'h00, sel}, 13'h007f);
            check({12'h000, unmapped_q}, 13'h0001);
            check({rtc_hours, rtc_minutes[5:0], 2'b00}, 13'h0000);
        end
    endtask
    // boundaries of every window, back to back
    task automatic t_decode;
        logic [12:0] a;
        logic [6:0] e;
        begin
            for (int i = 0; i < 20; i++)
            begin
                a = tbl[i];
                e = exp_sel(a);
                bus_cycle(a);
                check({6'h00, sel}, {6'h00, e});
                check({12'h000, unmapped_q}, {12'h000, &e});
                check({3'h0, nvram_addr_q}, e[5] ? 13'h0 : a - 13'h0100);
                check(eprom_addr_q, e[6] ? 13'h0 : a);
            end
        end
    endtask
    // second period, then the carry from 59 seconds into the minutes
    task automatic t_rtc;
        int n;
        begin
            wait_flip(0, 2 * SEC, n);
            wait_flip(0, 2 * SEC, n);
            check(13'(n), 13'(SEC));
            wait_flip(1, 62 * SEC, n);
            check({1'b0, rtc_minutes, rtc_seconds}, 13'h0040);
        end
    endtask
    // beep tone runs at the chosen half period and stops when disabled
    task automatic t_tone;
        int n;
        begin
            tone_enable <= 1'b1;
            wait_flip(2, 30, n);
            wait_flip(2, 30, n);
            check(13'(n), 13'(HALF));
            tone_enable <= 1'b0;
            repeat (6) @(posedge clk);
            check({12'h000, tone}, 13'h0000);
        end
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        rst_n = 1'b0;
        cpu_start = 1'b0;
        cpu_addr = 13'h0000;
        tone_enable = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_state();
        t_decode();
        t_rtc();
        t_tone();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
